/* File: logic/dtc_timer_ctrl.sv */
// Control, capture and register logic of the 8-bit and 16-bit counter/timers
`timescale 1ns/100ps
`default_nettype none
module dtc_timer_ctrl (
  input  wire logic                clk,              // System clock, 50 MHz
  input  wire logic                resetn,           // Power-on reset, async, active low
  input  wire logic                stop_recover,     // Stop-mode recovery reset pulse
  input  wire dtc_pkg::dtc_bus_type bus,             // Register write strobe and address
  output logic [7:0]               rdata,            // Read data of addressed register
  input  wire logic                demod_mode,       // High: demodulation, low: transmit
  input  wire logic                demod_in,         // Monitored input signal level
  input  wire logic [7:0]          narrow_count,     // Count of the eight_bit_timer
  input  wire logic                narrow_tc,        // eight_bit_timer terminal count pulse
  input  wire logic                pingpong,         // Ping-pong mode selected
  input  wire logic                port_latch,       // Port output latch bit
  output logic                     shared_port_pin,  // Steered pin level
  output logic                     wide_out,         // sixteen_bit_timer output level
  output logic                     narrow_run,       // eight_bit_timer enable
  output logic                     sync_en,          // Synchronised operation enable
  output logic                     cap_irq,          // Capture interrupt request pulse
  output logic                     tmo_irq           // Timeout interrupt request pulse
);
  import dtc_pkg::*;

  // ************************************************************
  // Block state
  // ************************************************************
  typedef struct packed {
    logic        wide_run;      // wide_run_bit
    logic        single;        // Single pass / first edge only
    logic        timeout;       // Terminal count flag
    logic [1:0]  presc;         // wide_prescale_select
    logic        cap_mask;      // Capture interrupt enable
    logic        tmo_mask;      // Timeout interrupt enable
    logic        steer;         // pin_steer_select
    logic        narrow_run;    // eight_bit_timer enable
    logic        sync_en;       // Sync mode
    logic [7:0]  reload_hi;     // wide_reload_upper
    logic [7:0]  reload_lo;     // Companion low hold byte
    logic [15:0] count;         // sixteen_bit_timer down counter
    logic [7:0]  wcap_hi;       // wide_capture_upper
    logic [7:0]  wcap_lo;       // wide_capture_lower
    logic [7:0]  ncap_hi;       // narrow_high_phase_capture
    logic [7:0]  ncap_lo;       // narrow_low_phase_capture
    logic        in_prev;       // Previous monitored input level
    logic        first_done;    // First edge already taken
    logic        tout;          // Timer output level
    logic        pin;           // Registered pin level
    logic [7:0]  rdata;         // Registered read data
    logic        cap_irq;       // Capture request pulse
    logic        tmo_irq;       // Timeout request pulse
  } dtc_state_type;

  dtc_state_type s_reg;        // Registered state
  dtc_state_type s_next;       // Next state
  logic          tick;         // Prescaled count tick
  logic          at_tc;        // Terminal count this cycle
  logic          edge_seen;    // Monitored input changed
  logic          cap_take;     // Demodulation capture taken
  logic [15:0]   reload;       // Full reload word

  // ************************************************************
  // Prescaler
  // ************************************************************
  dtc_prescaler u_pre (
    .clk    (clk),
    .resetn (resetn),
    .run    (s_reg.wide_run),
    .sel    (s_reg.presc),
    .tick   (tick)
  );

  // ************************************************************
  // Next-state logic
  // ************************************************************
  // Writes are applied first so that hardware events in the same cycle win
  always_comb begin
    s_next         = s_reg;
    s_next.cap_irq = 1'b0;
    s_next.tmo_irq = 1'b0;
    reload         = {s_reg.reload_hi, s_reg.reload_lo};
    edge_seen      = demod_in != s_reg.in_prev;
    at_tc          = s_reg.wide_run && tick && (s_reg.count == DTC_RST_WORD);
    cap_take       = demod_mode && s_reg.wide_run && edge_seen
                     && !(s_reg.single && s_reg.first_done);
    s_next.in_prev = demod_in;

    // Software writes; capture offsets fall through unchanged
    if (bus.wr) begin
      case (bus.addr)
        DTC_OFS_WIDE_CTRL: begin
          s_next.wide_run = bus.wdata[DTC_BIT_RUN];
          s_next.single   = bus.wdata[DTC_BIT_SINGLE];
          if (bus.wdata[DTC_BIT_TMO]) begin
            s_next.timeout = 1'b0;
          end
          s_next.presc    = bus.wdata[DTC_BIT_PRE_HI:DTC_BIT_PRE_LO];
          s_next.cap_mask = bus.wdata[DTC_BIT_CAPMSK];
          s_next.tmo_mask = bus.wdata[DTC_BIT_TMOMSK];
          s_next.steer    = bus.wdata[DTC_BIT_STEER];
        end
        DTC_OFS_JOINT_CTRL: begin
          s_next.wide_run   = bus.wdata[DTC_BIT_RUN];
          s_next.narrow_run = bus.wdata[DTC_BIT_NRUN];
          s_next.sync_en    = bus.wdata[DTC_BIT_SYNC];
        end
        DTC_OFS_RELOAD_LO: begin
          s_next.reload_lo = bus.wdata;
        end
        DTC_OFS_RELOAD_HI: begin
          s_next.reload_hi = bus.wdata;
        end
        default: begin
          // Capture and unmapped offsets ignore writes
        end
      endcase
      // A fresh start loads the reload word and re-arms first edge
      if (s_next.wide_run && !s_reg.wide_run) begin
        s_next.count      = reload;
        s_next.first_done = 1'b0;
      end
    end

    // Counting and terminal count
    if (at_tc) begin
      s_next.timeout = 1'b1;
      s_next.tmo_irq = s_reg.tmo_mask;
      s_next.count   = reload;
      if (!demod_mode) begin
        s_next.tout = !s_reg.tout;
        if (s_reg.single) begin
          s_next.wide_run = 1'b0;
        end
      end
    end else if (s_reg.wide_run && tick) begin
      s_next.count = s_reg.count - 16'h0001;
    end

    // Demodulation capture and reload on an input edge
    if (cap_take) begin
      s_next.wcap_hi    = s_reg.count[15:8];
      s_next.wcap_lo    = s_reg.count[7:0];
      s_next.count      = reload;
      s_next.first_done = 1'b1;
      s_next.cap_irq    = s_reg.cap_mask;
    end

    // Narrow timer phase captures
    if (edge_seen && !demod_in) begin
      s_next.ncap_hi = narrow_count;
    end
    if (edge_seen && demod_in) begin
      s_next.ncap_lo = narrow_count;
    end

    // Ping-pong hands the run enable from one timer to the other
    if (pingpong && at_tc) begin
      s_next.wide_run   = 1'b0;
      s_next.narrow_run = 1'b1;
    end
    if (pingpong && narrow_tc) begin
      s_next.narrow_run = 1'b0;
      s_next.wide_run   = 1'b1;
      s_next.count      = reload;
    end

    // Pin steering
    s_next.pin = s_reg.steer ? s_reg.tout : port_latch;

    // Read mux; the capture registers return the last captured value
    case (bus.addr)
      DTC_OFS_WIDE_CTRL:  s_next.rdata = {s_reg.wide_run, s_reg.single, s_reg.timeout,
                                          s_reg.presc, s_reg.cap_mask, s_reg.tmo_mask,
                                          s_reg.steer};
      DTC_OFS_JOINT_CTRL: s_next.rdata = {s_reg.wide_run, s_reg.narrow_run,
                                          s_reg.sync_en, 5'h00};
      DTC_OFS_RELOAD_LO:  s_next.rdata = s_reg.reload_lo;
      DTC_OFS_RELOAD_HI:  s_next.rdata = s_reg.reload_hi;
      DTC_OFS_WCAP_LO:    s_next.rdata = s_reg.wcap_lo;
      DTC_OFS_WCAP_HI:    s_next.rdata = s_reg.wcap_hi;
      DTC_OFS_NCAP_LO:    s_next.rdata = s_reg.ncap_lo;
      DTC_OFS_NCAP_HI:    s_next.rdata = s_reg.ncap_hi;
      default:            s_next.rdata = DTC_RST_BYTE;
    endcase

    // Stop recovery clears the other control fields but keeps the three marked ones: presc, cap_mask, sync_en
    if (stop_recover) begin
      s_next.wide_run   = 1'b0;
      s_next.single     = 1'b0;
      s_next.timeout    = 1'b0;
      s_next.tmo_mask   = 1'b0;
      s_next.steer      = 1'b0;
      s_next.narrow_run = 1'b0;
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  // Power-on reset clears every field, including the kept ones
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_reg       <= '0;
      s_reg.presc <= DTC_RST_PRE;
    end else begin
      s_reg <= s_next;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign rdata           = s_reg.rdata;
  assign shared_port_pin = s_reg.pin;
  assign wide_out        = s_reg.tout;
  assign narrow_run      = s_reg.narrow_run;
  assign sync_en         = s_reg.sync_en;
  assign cap_irq         = s_reg.cap_irq;
  assign tmo_irq         = s_reg.tmo_irq;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  ncap_high_a: assert property ((demod_in != s_reg.in_prev && !demod_in) |=>
    s_reg.ncap_hi == $past(narrow_count)) else $error("high-phase capture missed");
  ncap_low_a: assert property ((demod_in != s_reg.in_prev && demod_in) |=>
    s_reg.ncap_lo == $past(narrow_count)) else $error("low-phase capture missed");
  wcap_bytes_a: assert property (cap_take |=>
    {s_reg.wcap_hi, s_reg.wcap_lo} == $past(s_reg.count)) else $error("wide capture wrong");
  cap_nowrite_a: assert property ((bus.wr && bus.addr == DTC_OFS_WCAP_HI && !cap_take) |=>
    $stable(s_reg.wcap_hi)) else $error("capture register written");
  run_write_a: assert property ((bus.wr && bus.addr == DTC_OFS_WIDE_CTRL && !at_tc
    && !narrow_tc && !stop_recover) |=> s_reg.wide_run == $past(bus.wdata[7]))
    else $error("run bit not taken");
  single_stop_a: assert property ((at_tc && !demod_mode && s_reg.single && !pingpong
    && !narrow_tc && !stop_recover) |=> !s_reg.wide_run) else $error("single pass ran on");
  // Once the first edge is taken in single mode the capture bytes must not move
  first_only_a: assert property ((demod_mode && s_reg.single && s_reg.first_done)
    |=> $stable(s_reg.wcap_hi) && $stable(s_reg.wcap_lo)) else $error("later edge captured");
  tmo_set_a: assert property ((at_tc && !stop_recover) |=> s_reg.timeout)
    else $error("timeout flag not set");
  cap_pulse_a: assert property (cap_irq |=> !cap_irq) else $error("capture irq not a pulse");
  tmo_irq_a: assert property ((at_tc && s_reg.tmo_mask) |=> tmo_irq ##1 !tmo_irq)
    else $error("timeout irq wrong");
  cap_irq_a: assert property ((cap_take && s_reg.cap_mask) |=> cap_irq)
    else $error("capture irq missing");
  pin_steer_a: assert property (s_reg.steer |=> shared_port_pin == $past(s_reg.tout))
    else $error("pin not steered");
  smr_keep_a: assert property ((stop_recover && !bus.wr) |=> $stable(s_reg.presc)
    && $stable(s_reg.cap_mask) && $stable(s_reg.sync_en) && !s_reg.wide_run)
    else $error("stop recovery fields wrong");
  pp_swap_a: assert property ((pingpong && at_tc && !narrow_tc && !stop_recover) |=>
    narrow_run && !s_reg.wide_run) else $error("ping-pong swap missed");

  reload_cov_c: cover property (at_tc && !demod_mode && !s_reg.single);
  capture_cov_c: cover property (cap_take ##[1:20] cap_take);
  pingpong_cov_c: cover property (pingpong && at_tc ##[1:50] narrow_tc);

endmodule // dtc_timer_ctrl
`default_nettype wire

/* File: common/dtc_pkg.sv */
// Package of constants and carrier types for the dual timer capture control block
// Overview of operation
// - Falling input edge stores narrow count high-phase
// - Rising input edge stores narrow count low-phase
// - Wide capture upper byte high, lower low
// - Capture registers ignore writes, read last capture
// - Control bit 7 starts/stops wide timer
// - Transmit: bit 6 reload or single pass
// - Demodulation: bit 6 every edge or first
// - Bit 5 timeout flag, write one clears
// - Bits 4:3 select clock divide 1/2/4/8
// - Capture interrupt pulse when mask bit 2
// - Timeout interrupt pulse when mask bit 1
// - Bit 0 steers pin to timer output
// - Stop recovery keeps prescale, capture mask, sync
// - Joint register starts both timers, sync bit
// - Ping-pong alternates enables, sets wide timeout flag
package dtc_pkg;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [3:0] DTC_OFS_WIDE_CTRL   = 4'h2;
  localparam logic [3:0] DTC_OFS_JOINT_CTRL  = 4'h3;
  localparam logic [3:0] DTC_OFS_RELOAD_LO   = 4'h6;
  localparam logic [3:0] DTC_OFS_RELOAD_HI   = 4'h7;
  localparam logic [3:0] DTC_OFS_WCAP_LO     = 4'h8;
  localparam logic [3:0] DTC_OFS_WCAP_HI     = 4'h9;
  localparam logic [3:0] DTC_OFS_NCAP_LO     = 4'hA;
  localparam logic [3:0] DTC_OFS_NCAP_HI     = 4'hB;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int DTC_BIT_RUN     = 7;
  localparam int DTC_BIT_SINGLE  = 6;
  localparam int DTC_BIT_TMO     = 5;
  localparam int DTC_BIT_PRE_HI  = 4;
  localparam int DTC_BIT_PRE_LO  = 3;
  localparam int DTC_BIT_CAPMSK  = 2;
  localparam int DTC_BIT_TMOMSK  = 1;
  localparam int DTC_BIT_STEER   = 0;
  localparam int DTC_BIT_NRUN    = 6;
  localparam int DTC_BIT_SYNC    = 5;

  // ************************************************************
  // Reset values and timing
  // ************************************************************
  localparam logic [7:0]  DTC_RST_BYTE  = 8'h00;
  localparam logic [15:0] DTC_RST_WORD  = 16'h0000;
  localparam logic [1:0]  DTC_RST_PRE   = 2'h0;
  localparam logic [2:0]  DTC_PRE_MAX   = 3'h7;

  // Register write strobe with its address and data
  typedef struct packed {
    logic       wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } dtc_bus_type;

endpackage

/* File: logic/dtc_prescaler.sv */
// Prescaler that turns the system clock into the wide timer count tick
`timescale 1ns/100ps
`default_nettype none
module dtc_prescaler (
  input  wire logic       clk,      // System clock
  input  wire logic       resetn,   // Asynchronous power-on reset
  input  wire logic       run,      // Counting enabled; holds divider cleared when low
  input  wire logic [1:0] sel,      // Divide select
  output logic            tick      // One-cycle count tick
);
  import dtc_pkg::*;

  // ************************************************************
  // Divider state
  // ************************************************************
  typedef struct packed {
    logic [2:0] cnt;   // Free divider count
  } dtc_pre_state_type;

  dtc_pre_state_type s_reg;   // Registered state
  dtc_pre_state_type s_next;  // Next state
  logic [2:0]        mask;    // Low bits that must be zero for a tick

  // Tick when the selected low bits of the divider are all zero
  always_comb begin
    s_next = s_reg;
    mask   = DTC_PRE_MAX >> (2'h3 - sel);
    s_next.cnt = run ? s_reg.cnt + 3'h1 : 3'h0;
    tick   = run && ((s_reg.cnt & mask) == 3'h0);
  end

  // Register the divider
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Divide by 8 gives exactly one tick in eight running cycles
  pre_div8_a: assert property (@(posedge clk) disable iff (!resetn)
    (run && sel == 2'h3 && tick) |=> (!tick) [*7]) else $error("divide by 8 ticks early");

endmodule // dtc_prescaler
`default_nettype wire

/* File: tb/test_dual_timer_capture_control.sv */
// Self-checking bench for the dual timer capture control block
`timescale 1ns/100ps
`default_nettype none
module test_dual_timer_capture_control;
  import dtc_pkg::*;
  // ************************************************************
  // Stimulus and observed signals
  // ************************************************************
  logic        clk;             // System clock, 50 MHz
  logic        resetn;          // Power-on reset
  logic        stop_recover;    // Stop-mode recovery pulse
  dtc_bus_type bus;             // Register write strobe
  logic [7:0]  rdata;           // Register read data
  logic        demod_mode;      // Mode select
  logic        demod_in;        // Monitored input
  logic [7:0]  narrow_count;    // Narrow timer count
  logic        narrow_tc;       // Narrow terminal count
  logic        pingpong;        // Ping-pong select
  logic        port_latch;      // Port latch bit
  logic        shared_port_pin; // Steered pin
  logic        wide_out;        // Wide timer output
  logic        narrow_run;      // Narrow enable
  logic        sync_en;         // Sync enable
  logic        cap_irq;         // Capture request
  logic        tmo_irq;         // Timeout request
  int          errors;          // Mismatches
  int          n_compared;      // Comparisons
  int          n;               // Cycle count
  int          k;               // Pulse count
  logic [7:0]  v;               // Read value
  logic        w;               // Earlier output level

  dtc_timer_ctrl dut_u (.clk(clk), .resetn(resetn), .stop_recover(stop_recover),
    .bus(bus), .rdata(rdata), .demod_mode(demod_mode), .demod_in(demod_in),
    .narrow_count(narrow_count), .narrow_tc(narrow_tc), .pingpong(pingpong),
    .port_latch(port_latch), .shared_port_pin(shared_port_pin), .wide_out(wide_out),
    .narrow_run(narrow_run), .sync_en(sync_en), .cap_irq(cap_irq), .tmo_irq(tmo_irq));

  // Free-running clock
  initial clk = 1'b0;
  always #10 clk = ~clk;

  // ************************************************************
  // Access and check tasks
  // ************************************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic chk1(input logic seen, input logic exp);
    chk({7'h0, seen}, {7'h0, exp});
  endtask
  // Every task starts and ends just after a rising edge
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  // The strobe drops for one idle edge, so back-to-back writes never re-raise it at once
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus = {1'b1, a, d};
    cyc(1);
    bus.wr = 1'b0;
    cyc(1);
  endtask
  // Read data is registered, so it is taken one edge after the address
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    bus.addr = a;
    cyc(1);
    d = rdata;
  endtask
  // Bounded wait for a request pulse; a lost pulse ends the run
  task automatic wait_irq(input bit cap, output int c);
    c = 0;
    do begin
      cyc(1);
      c++;
    end while ((cap ? cap_irq : tmo_irq) !== 1'b1 && c < 300);
    if (c >= 300) begin
      errors++;
      tally_and_finish();
    end
  endtask
  // Counts request pulses over twenty cycles
  task automatic quiet(input bit cap, output int c);
    c = 0;
    repeat (20) begin
      cyc(1);
      if ((cap ? cap_irq : tmo_irq) !== 1'b0) c++;
    end
  endtask
  task automatic tally_and_finish;
    $display("compared=%0d errors=%0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    errors = 0;
    n_compared = 0;
    resetn = 1'b0;
    stop_recover = 1'b0;
    bus = '0;
    demod_mode = 1'b0;
    demod_in = 1'b0;
    narrow_count = 8'h00;
    narrow_tc = 1'b0;
    pingpong = 1'b0;
    port_latch = 1'b0;
    repeat (20) @(posedge clk);
    #1 resetn = 1'b1;
    // Reset values, unmapped place reads zero
    rd(4'h2, v); chk(v, 8'h00);
    rd(4'h3, v); chk(v, 8'h00);
    rd(4'hF, v); chk(v, 8'h00);
    // Capture places refuse writes
    for (int a = 8; a < 12; a++) begin
      wr(4'(a), 8'hFF);
      rd(4'(a), v); chk(v, 8'h00);
    end
    // Hold bytes, short reload of 3 for quick terminal counts
    wr(4'h6, 8'h03);
    wr(4'h7, 8'hA5);
    rd(4'h7, v); chk(v, 8'hA5);
    wr(4'h7, 8'h00);
    rd(4'h6, v); chk(v, 8'h03);
    // Modulo-N period is (reload+1) ticks at every divide setting
    for (int p = 0; p < 4; p++) begin
      wr(4'h2, 8'h83 | 8'(p << 3));
      wait_irq(1'b0, n);
      w = wide_out;
      wait_irq(1'b0, n); chk(8'(n), 8'(4 << p));
      chk1(wide_out, ~w);
      cyc(1); chk1(tmo_irq, 1'b0);
      wr(4'h2, 8'h01);
      cyc(2); chk1(shared_port_pin, wide_out);
    end
    // Flag survives a write of 0, clears on a write of 1
    rd(4'h2, v); chk(v, 8'h21);
    wr(4'h2, 8'h20);
    rd(4'h2, v); chk(v, 8'h00);
    port_latch = 1'b1;
    cyc(2); chk1(shared_port_pin, 1'b1);
    port_latch = 1'b0;
    cyc(2); chk1(shared_port_pin, 1'b0);
    // Single pass, first with the timeout mask bit clear, then with it set
    wr(4'h2, 8'hC0);
    quiet(1'b0, k); chk(8'(k), 8'h00);
    rd(4'h2, v); chk(v, 8'h60);
    wr(4'h2, 8'hE2);
    wait_irq(1'b0, n);
    quiet(1'b0, k); chk(8'(k), 8'h00);
    rd(4'h2, v); chk(v, 8'h62);
    // Demodulation: stopped before the mode changes
    wr(4'h2, 8'h20);
    demod_mode = 1'b1;
    wr(4'h6, 8'h34);
    wr(4'h7, 8'h12);
    wr(4'h2, 8'h84);
    narrow_count = 8'h5A;
    demod_in = 1'b1;
    wait_irq(1'b1, n);
    cyc(1); chk1(cap_irq, 1'b0);
    rd(4'hA, v); chk(v, 8'h5A);
    rd(4'h9, v); chk(v, 8'h12);
    // One undivided tick passed between the start and the edge
    rd(4'h8, v); chk(v, 8'h33);
    narrow_count = 8'hA5;
    demod_in = 1'b0;
    wait_irq(1'b1, n);
    rd(4'hB, v); chk(v, 8'hA5);
    // First edge only, then capture mask off
    wr(4'h2, 8'h04);
    wr(4'h2, 8'hC4);
    demod_in = 1'b1;
    wait_irq(1'b1, n);
    demod_in = 1'b0;
    quiet(1'b1, k); chk(8'(k), 8'h00);
    wr(4'h2, 8'h00);
    wr(4'h2, 8'h80);
    demod_in = 1'b1;
    quiet(1'b1, k); chk(8'(k), 8'h00);
    wr(4'h2, 8'h00);
    demod_mode = 1'b0;
    // Stop-mode recovery keeps only the marked fields
    wr(4'h3, 8'h20);
    wr(4'h2, 8'h9F);
    stop_recover = 1'b1;
    cyc(1);
    stop_recover = 1'b0;
    rd(4'h2, v); chk(v, 8'h1C);
    rd(4'h3, v); chk(v, 8'h20);
    chk1(sync_en, 1'b1);
    // Joint start and stop of both timers
    wr(4'h3, 8'hC0);
    rd(4'h2, v); chk(v, 8'h9C);
    rd(4'h3, v); chk(v, 8'hC0);
    chk1(narrow_run, 1'b1);
    wr(4'h3, 8'h00);
    rd(4'h3, v); chk(v, 8'h00);
    // Ping-pong hand-over in both directions
    wr(4'h6, 8'h03);
    wr(4'h7, 8'h00);
    wr(4'h2, 8'h02);
    pingpong = 1'b1;
    wr(4'h3, 8'h80);
    wait_irq(1'b0, n);
    rd(4'h3, v); chk(v, 8'h40);
    rd(4'h2, v); chk(v, 8'h22);
    narrow_tc = 1'b1;
    cyc(1);
    narrow_tc = 1'b0;
    rd(4'h3, v); chk(v, 8'h80);
    tally_and_finish();
  end
endmodule // test_dual_timer_capture_control
`default_nettype wire
